// File: bench/boost_seq_properties.sv
`timescale 1ns/1ps
module boost_seq_properties (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// watched ports
	input wire logic fbAboveRef,
	input wire logic powerStageHiZ,
	input wire logic prechargeSourceOn,
	input wire logic halfCurrentLimit,
	input wire logic loopClosed,
	input wire logic boostSwitchOn,
	input wire logic auxOutputOn,
	input wire logic statusPinPulse,
	input wire logic boostActive
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// feedback held above reference while regulating
	sequence fbHeld;
		(loopClosed && fbAboveRef)[*4];
	endsequence
	sequence stageIdle;
		!(boostSwitchOn || prechargeSourceOn || loopClosed || halfCurrentLimit);
	endsequence
	pulse_one_cycle_a: assert property (statusPinPulse |=> !statusPinPulse)
		else $error("status pulse longer than one cycle");
	fault_to_idle_a: assert property (statusPinPulse |-> ##[0:2] powerStageHiZ)
		else $error("fault did not return stage to idle");
	hiz_stage_idle_a: assert property (powerStageHiZ |-> stageIdle)
		else $error("stage active while high impedance");
	aux_off_boost_a: assert property (auxOutputOn |-> !boostActive)
		else $error("aux output on during boost");
	fb_blocks_switch_a: assert property (fbHeld |-> !boostSwitchOn)
		else $error("switch on with feedback above reference");
	soft_after_pre_a: assert property ($rose(halfCurrentLimit) |-> $past(prechargeSourceOn))
		else $error("soft start not entered from precharge");
	half_limit_open_a: assert property (halfCurrentLimit |-> boostSwitchOn && !loopClosed)
		else $error("half limit without open loop switching");
	start_in_precharge_a: assert property ($rose(boostActive) |-> prechargeSourceOn)
		else $error("boost started outside precharge");
endmodule : boost_seq_properties

// File: bench/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
	// clock
	input wire logic clk_sys,
	// stage control
	input wire logic prechargeSourceOn,
	input wire logic boostSwitchOn,
	input wire logic powerStageHiZ,
	// plant knobs
	input wire logic midOk,
	input wire logic bandOk,
	// comparators
	output logic midNearBat,
	output logic busInBand
);
	logic [4:0] preCnt_r;
	logic [4:0] swCnt_r;
	// nodes discharge whenever the stage is released
	always_ff @(posedge clk_sys)
	begin
		if (!midOk || powerStageHiZ)
			preCnt_r <= 5'h00;
		else if (prechargeSourceOn && preCnt_r != 5'h14)
			preCnt_r <= preCnt_r + 5'h01;
		if (!bandOk || powerStageHiZ)
			swCnt_r <= 5'h00;
		else if (boostSwitchOn && swCnt_r != 5'h14)
			swCnt_r <= swCnt_r + 5'h01;
	end
	assign midNearBat = preCnt_r == 5'h14;
	assign busInBand = swCnt_r == 5'h14;
endmodule : power_stage_model

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
	import boost_seq_pkg::*;
	logic clk_sys, resetn, regWrEn, regRdEn, hostModePin, midAboveBat, fbAboveRef;
	logic busPowerOnReset;
	logic watchdogExpired, midOk, bandOk;
	logic [7:0] regAddr, regWrData, regRdData, monitorRaw, rdv;
	logic [3:0] fs;
	wire logic midNearBat, busInBand, powerStageHiZ, prechargeSourceOn, halfCurrentLimit;
	wire logic loopClosed, boostSwitchOn, auxOutputOn, statusPinPulse, boostActive;
	int miscompares, check_count, cnt;
	logic [7:0] ra [6] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'h20, 8'h10};
	logic [7:0] re [6] = '{8'h40, 8'h30, 8'h00, 8'h00, 8'h00, 8'hA5};
	logic [2:0] fc [4] = '{3'h1, 3'h3, 3'h5, 3'h2};
	boost_startup_fault_sequencer #(.FIRST_RESTART_US(20), .RETRY_US(10)) dut (
		.clk_sys(clk_sys), .resetn(resetn), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.hostModePin(hostModePin), .busPowerOnReset(busPowerOnReset), .batAboveUvlo(!fs[1]),
		.midNearBat(midNearBat), .midAboveBat(midAboveBat), .busInBand(busInBand),
		.fbAboveRef(fbAboveRef), .busOverVoltage(fs[0]), .currentLimitHit(fs[3]),
		.thermalShutdown(fs[2]), .watchdogExpired(watchdogExpired), .monitorRaw(monitorRaw),
		.powerStageHiZ(powerStageHiZ), .prechargeSourceOn(prechargeSourceOn),
		.halfCurrentLimit(halfCurrentLimit), .loopClosed(loopClosed),
		.boostSwitchOn(boostSwitchOn), .auxOutputOn(auxOutputOn),
		.statusPinPulse(statusPinPulse), .boostActive(boostActive));
	power_stage_model plant (.clk_sys(clk_sys), .prechargeSourceOn(prechargeSourceOn),
		.boostSwitchOn(boostSwitchOn), .powerStageHiZ(powerStageHiZ), .midOk(midOk),
		.bandOk(bandOk), .midNearBat(midNearBat), .busInBand(busInBand));
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrEn <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		#1 rdv = regRdData;
	endtask : rd
	function automatic logic pick(input int s);
		case (s)
			0: return loopClosed;
			1: return statusPinPulse;
			2: return prechargeSourceOn;
			default: return halfCurrentLimit;
		endcase
	endfunction : pick
	// cnt returns the cycles spent waiting
	task automatic waitFor(input int s, input logic lvl, input int lim);
		cnt = 0;
		while (pick(s) !== lvl)
		begin
			tick(1);
			cnt++;
			if (cnt > lim)
			begin
				miscompares++;
				$display("[FAIL] wait %0d expected %0b seen timeout", s, lvl);
				final_report();
			end
		end
	endtask : waitFor
	initial
	begin
		miscompares = 0;
		check_count = 0;
		{resetn, regWrEn, regRdEn, hostModePin, midAboveBat, fbAboveRef, busPowerOnReset} = 7'h00;
		{watchdogExpired, midOk, bandOk, fs} = 7'h30;
		{regAddr, regWrData, monitorRaw} = {8'h00, 8'h00, 8'hA5};
		tick(8);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			rd(ra[i]);
			chk("reset value", rdv, re[i]);
		end
		monitorRaw <= 8'h5A;
		wr(MONITOR_OFFSET, 8'h00);
		rd(MONITOR_OFFSET);
		chk("monitor", rdv, 8'h5A);
		$display("test registers done");
		midAboveBat <= 1'b1;
		tick(4);
		chk("aux on", auxOutputOn, 1'b1);
		wr(AUX_CTRL_OFFSET, 8'h40);
		tick(4);
		chk("aux disabled", auxOutputOn, 1'b0);
		wr(AUX_CTRL_OFFSET, 8'h00);
		wr(CTRL1_OFFSET, 8'h32);
		tick(4);
		chk("aux hiz", auxOutputOn, 1'b0);
		wr(CTRL1_OFFSET, 8'h30);
		$display("test aux done");
		for (int k = 0; k < 4; k++)
		begin
			wr(CTRL1_OFFSET, 8'h31);
			waitFor(0, 1'b1, 200);
			fbAboveRef <= 1'b1;
			tick(5);
			chk("switch held off", boostSwitchOn, 1'b0);
			fbAboveRef <= 1'b0;
			rd(CTRL0_OFFSET);
			chk("boost bit", rdv[3], 1'b1);
			fs <= 4'h1 << k;
			waitFor(1, 1'b1, 6000);
			chk("stage hi-z", powerStageHiZ, 1'b1);
			fs <= 4'h0;
			rd(CTRL0_OFFSET);
			chk("fault code", rdv[2:0], fc[k]);
			rd(CTRL1_OFFSET);
			chk("request cleared", rdv, 8'h30);
			tick(300);
			chk("no self restart", boostActive, 1'b0);
			rd(CTRL0_OFFSET);
			chk("fault read clear", rdv[2:0], 3'h0);
		end
		wr(CTRL1_OFFSET, 8'h31);
		waitFor(0, 1'b1, 200);
		fs <= 4'h1;
		waitFor(1, 1'b1, 50);
		fs <= 4'h0;
		busPowerOnReset <= 1'b1;
		tick(4);
		busPowerOnReset <= 1'b0;
		rd(CTRL0_OFFSET);
		chk("por clears fault", rdv[2:0], 3'h0);
		$display("test faults done");
		bandOk <= 1'b0;
		wr(CTRL1_OFFSET, 8'h31);
		waitFor(3, 1'b1, 200);
		waitFor(3, 1'b0, 14000);
		chk("soft low span", cnt > 12795 && cnt < 12810, 1'b1);
		chk("still soft", boostSwitchOn && !loopClosed, 1'b1);
		bandOk <= 1'b1;
		waitFor(0, 1'b1, 200);
		wr(CTRL1_OFFSET, 8'h30);
		$display("test soft start done");
		hostModePin <= 1'b1;
		wr(PIN_CTRL_OFFSET, 8'h01);
		tick(50);
		chk("pin inactive", boostActive, 1'b0);
		rd(CTRL0_OFFSET);
		chk("pin level", rdv[7], 1'b1);
		wr(PIN_CTRL_OFFSET, 8'h03);
		waitFor(0, 1'b1, 300);
		fs <= 4'h1;
		waitFor(1, 1'b1, 50);
		waitFor(2, 1'b1, 3000);
		chk("first restart", cnt > 1995 && cnt < 2010, 1'b1);
		waitFor(1, 1'b1, 100);
		waitFor(2, 1'b1, 2000);
		chk("retry span", cnt > 995 && cnt < 1010, 1'b1);
		fs <= 4'h0;
		waitFor(0, 1'b1, 2000);
		wr(AUX_CTRL_OFFSET, 8'h40);
		watchdogExpired <= 1'b1;
		waitFor(1, 1'b1, 20);
		watchdogExpired <= 1'b0;
		rd(CTRL0_OFFSET);
		chk("timer code", rdv[2:0], 3'h6);
		rd(AUX_CTRL_OFFSET);
		chk("aux reg default", rdv, 8'h00);
		rd(PIN_CTRL_OFFSET);
		chk("pin reg default", rdv, 8'h00);
		tick(2500);
		chk("no restart", boostActive, 1'b0);
		$display("test pin restart done");
		midOk <= 1'b0;
		wr(CTRL1_OFFSET, 8'h31);
		waitFor(2, 1'b1, 100);
		waitFor(2, 1'b0, 57000);
		chk("precharge span", cnt > 55995 && cnt < 56010, 1'b1);
		rd(CTRL0_OFFSET);
		chk("precharge code", rdv[2:0], 3'h2);
		$display("test precharge timeout done");
		final_report();
	end
endmodule : tb
bind boost_startup_fault_sequencer boost_seq_properties chk_i (.clk_sys(clk_sys),
	.resetn(resetn), .fbAboveRef(fbAboveRef), .powerStageHiZ(powerStageHiZ),
	.prechargeSourceOn(prechargeSourceOn), .halfCurrentLimit(halfCurrentLimit),
	.loopClosed(loopClosed), .boostSwitchOn(boostSwitchOn), .auxOutputOn(auxOutputOn),
	.statusPinPulse(statusPinPulse), .boostActive(boostActive));

// File: rtl/boost_seq_pkg.sv
package boost_seq_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	// register offsets
	localparam logic [7:0] CTRL0_OFFSET = 8'h00;
	localparam logic [7:0] CTRL1_OFFSET = 8'h01;
	localparam logic [7:0] AUX_CTRL_OFFSET = 8'h05;
	localparam logic [7:0] PIN_CTRL_OFFSET = 8'h07;
	localparam logic [7:0] MONITOR_OFFSET = 8'h10;
	// field positions
	localparam int unsigned CTRL0_PIN_LEVEL_BIT = 7;
	localparam int unsigned CTRL0_STAT_EN_BIT = 6;
	localparam int unsigned CTRL0_BOOST_BIT = 3;
	localparam int unsigned CTRL1_HIZ_BIT = 1;
	localparam int unsigned CTRL1_REQ_BIT = 0;
	localparam int unsigned AUX_DISABLE_BIT = 6;
	localparam int unsigned PIN_ENABLE_BIT = 0;
	localparam int unsigned PIN_POLARITY_BIT = 1;
	// reset values
	localparam logic CTRL0_STAT_EN_RESET = 1'b1;
	localparam logic [7:0] CTRL1_RESET = 8'h30;
	localparam logic [7:0] AUX_CTRL_RESET = 8'h00;
	localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
	// timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_NS = 1000;
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W = 13;
	localparam int unsigned PRECHARGE_US = 560;
	localparam int unsigned SOFT_LOW_US = 128;
	localparam int unsigned SOFT_FULL_US = 384;
	localparam int unsigned ILIMIT_US = 50;
	localparam int unsigned FIRST_RESTART_US = 5200;
	localparam int unsigned RETRY_US = 5000;
	// fault codes
	typedef enum logic [2:0] {
		FAULT_NONE = 3'h0,
		FAULT_BUS_OVP = 3'h1,
		FAULT_STARTUP = 3'h2,
		FAULT_BAT_UVLO = 3'h3,
		FAULT_THERMAL = 3'h5,
		FAULT_TIMER = 3'h6
	} fault_code_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_PRECHARGE = 6'b000010,
		ST_SOFT_LOW = 6'b000100,
		ST_SOFT_FULL = 6'b001000,
		ST_RUN = 6'b010000,
		ST_RESTART_WAIT = 6'b100000
	} seq_state_t;
endpackage : boost_seq_pkg

// File: rtl/boost_startup_fault_sequencer.sv
// What this block does
// - enable rise with battery ok starts precharge
// - precharge not done in 560us faults
// - precharge done enters soft start, half limit
// - bus in band closes loop, full limit
// - after 128us soft start, raise limit
// - not in band after 384us more faults
// - run: switch off while feedback above reference
// - fault: pulse status, clear request, hi-z, code
// - software start never restarts itself
// - pin start restarts after 5.2ms delay
// - persisting fault retries every 5ms
// - fault code values as defined
// - timer fault resets all registers except the fault code
// - aux output off when disable bit set
// - aux output off in boost or hi-z
// - monitor bits read live, unfiltered
// - monitor register layout at 10h
// - monitor in hi-z valid only with bus
// - boost enable from pin or register
// - polarity bit selects pin active level
// - reading control zero clears fault
`timescale 1ns/1ps
module boost_startup_fault_sequencer #(
	parameter int unsigned FIRST_RESTART_US = boost_seq_pkg::FIRST_RESTART_US,
	parameter int unsigned RETRY_US = boost_seq_pkg::RETRY_US
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [boost_seq_pkg::ADDR_W-1:0] regAddr,
	input wire logic [boost_seq_pkg::DATA_W-1:0] regWrData,
	output logic [boost_seq_pkg::DATA_W-1:0] regRdData,
	// pins
	input wire logic hostModePin,
	input wire logic busPowerOnReset,
	// comparators
	input wire logic batAboveUvlo,
	input wire logic midNearBat,
	input wire logic midAboveBat,
	input wire logic busInBand,
	input wire logic fbAboveRef,
	input wire logic busOverVoltage,
	input wire logic currentLimitHit,
	input wire logic thermalShutdown,
	input wire logic watchdogExpired,
	input wire logic [7:0] monitorRaw,
	// power stage control
	output logic powerStageHiZ,
	output logic prechargeSourceOn,
	output logic halfCurrentLimit,
	output logic loopClosed,
	output logic boostSwitchOn,
	output logic auxOutputOn,
	output logic statusPinPulse,
	output logic boostActive
);
	import boost_seq_pkg::*;

	localparam int unsigned IN_W = 19;

	if (FIRST_RESTART_US >= (1 << TIMER_W) || RETRY_US >= (1 << TIMER_W) || RETRY_US == 0)
	begin : g_bad_delay
		$error("restart delays do not fit the interval counter");
	end

	// two-flop synchronisers for pins and comparators
	logic [IN_W-1:0] syncA_r;
	logic [IN_W-1:0] syncB_r;

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			syncA_r <= '0;
			syncB_r <= '0;
		end
		else
		begin
			syncA_r <= {monitorRaw, watchdogExpired, thermalShutdown, currentLimitHit,
				busOverVoltage, fbAboveRef, busInBand, midAboveBat, midNearBat,
				batAboveUvlo, busPowerOnReset, hostModePin};
			syncB_r <= syncA_r;
		end
	end

	logic pinLevel;
	logic busPor;
	logic batOk;
	logic midNear;
	logic midAbove;
	logic inBand;
	logic fbAbove;
	logic ovp;
	logic ilimHit;
	logic thermal;
	logic watchdog;
	logic [7:0] monitorLive;

	assign {monitorLive, watchdog, thermal, ilimHit, ovp, fbAbove, inBand, midAbove, midNear,
		batOk, busPor, pinLevel} = syncB_r;

	// register state
	logic statEn_r;
	logic statEn_nxt;
	logic [2:0] faultCode_r;
	logic [2:0] faultCode_nxt;
	logic [7:0] ctrl1_r;
	logic [7:0] ctrl1_nxt;
	logic [7:0] auxCtrl_r;
	logic [7:0] auxCtrl_nxt;
	logic [7:0] pinCtrl_r;
	logic [7:0] pinCtrl_nxt;
	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;
	logic statusPulse_r;
	logic statusPulse_nxt;

	// sequencer state
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic retryPending_r;
	logic retryPending_nxt;
	logic firstRetry_r;
	logic firstRetry_nxt;
	logic enPrev_r;
	logic enPrev_nxt;
	logic [5:0] ilimCount_r;
	logic [5:0] ilimCount_nxt;

	interval_if tmr ();

	interval_timer u_timer (
		.clk_sys (clk_sys),
		.resetn (resetn),
		.tmr (tmr.counter)
	);

	logic hiZReq;
	logic boostReq;
	logic pinEnable;
	logic pinActive;
	logic boostEn;
	logic startEdge;
	logic running;
	logic faultNow;
	fault_code_t faultCode;

	assign hiZReq = ctrl1_r[CTRL1_HIZ_BIT];
	assign boostReq = ctrl1_r[CTRL1_REQ_BIT];
	assign pinEnable = pinCtrl_r[PIN_ENABLE_BIT];
	assign pinActive = pinLevel == pinCtrl_r[PIN_POLARITY_BIT];
	assign boostEn = (pinEnable && pinActive) || (!hiZReq && boostReq);
	assign startEdge = boostEn && !enPrev_r;
	assign running = (state_r != ST_IDLE) && (state_r != ST_RESTART_WAIT);

	// fault detection, priority highest first
	always_comb
	begin
		faultCode = FAULT_NONE;
		if (running)
		begin
			if (watchdog)
				faultCode = FAULT_TIMER;
			else if (thermal)
				faultCode = FAULT_THERMAL;
			else if (ovp)
				faultCode = FAULT_BUS_OVP;
			else if (!batOk)
				faultCode = FAULT_BAT_UVLO;
			else if (state_r == ST_PRECHARGE && tmr.expired && !midNear)
				faultCode = FAULT_STARTUP;
			else if (state_r == ST_SOFT_FULL && tmr.expired && !inBand)
				faultCode = FAULT_STARTUP;
			else if (state_r == ST_RUN && ilimCount_r >= 6'(ILIMIT_US))
				faultCode = FAULT_STARTUP;
		end
	end

	assign faultNow = faultCode != FAULT_NONE;

	// sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		retryPending_nxt = retryPending_r;
		firstRetry_nxt = firstRetry_r;
		enPrev_nxt = boostEn;
		ilimCount_nxt = '0;
		if (faultNow)
		begin
			state_nxt = ST_IDLE;
			retryPending_nxt = pinEnable && pinActive;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					if (retryPending_r)
					begin
						retryPending_nxt = 1'b0;
						if (pinEnable && pinActive)
							state_nxt = ST_RESTART_WAIT;
					end
					else if (startEdge && batOk)
					begin
						state_nxt = ST_PRECHARGE;
						firstRetry_nxt = 1'b1;
					end
				end
				ST_PRECHARGE:
				begin
					if (!boostEn)
						state_nxt = ST_IDLE;
					else if (midNear)
						state_nxt = ST_SOFT_LOW;
				end
				ST_SOFT_LOW:
				begin
					if (!boostEn)
						state_nxt = ST_IDLE;
					else if (inBand)
						state_nxt = ST_RUN;
					else if (tmr.expired)
						state_nxt = ST_SOFT_FULL;
				end
				ST_SOFT_FULL:
				begin
					if (!boostEn)
						state_nxt = ST_IDLE;
					else if (inBand)
						state_nxt = ST_RUN;
				end
				ST_RUN:
				begin
					firstRetry_nxt = 1'b1;
					if (ilimHit && tmr.tick)
						ilimCount_nxt = ilimCount_r + 6'h01;
					else if (ilimHit)
						ilimCount_nxt = ilimCount_r;
					if (!boostEn)
						state_nxt = ST_IDLE;
				end
				ST_RESTART_WAIT:
				begin
					if (!(pinEnable && pinActive))
						state_nxt = ST_IDLE;
					else if (tmr.expired)
					begin
						state_nxt = ST_PRECHARGE;
						firstRetry_nxt = 1'b0;
					end
				end
				default:
					state_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			state_r <= ST_IDLE;
			retryPending_r <= 1'b0;
			firstRetry_r <= 1'b1;
			enPrev_r <= 1'b0;
			ilimCount_r <= 6'h00;
		end
		else
		begin
			state_r <= state_nxt;
			retryPending_r <= retryPending_nxt;
			firstRetry_r <= firstRetry_nxt;
			enPrev_r <= enPrev_nxt;
			ilimCount_r <= ilimCount_nxt;
		end
	end

	// interval per state
	always_comb
	begin
		tmr.restart = state_nxt != state_r;
		case (state_r)
			ST_PRECHARGE:
				tmr.limit = TIMER_W'(PRECHARGE_US);
			ST_SOFT_LOW:
				tmr.limit = TIMER_W'(SOFT_LOW_US);
			ST_SOFT_FULL:
				tmr.limit = TIMER_W'(SOFT_FULL_US);
			ST_RESTART_WAIT:
				tmr.limit = firstRetry_r ? TIMER_W'(FIRST_RESTART_US) : TIMER_W'(RETRY_US);
			default:
				tmr.limit = {TIMER_W{1'b1}};
		endcase
	end

	// register file next values
	always_comb
	begin
		statEn_nxt = statEn_r;
		faultCode_nxt = faultCode_r;
		ctrl1_nxt = ctrl1_r;
		auxCtrl_nxt = auxCtrl_r;
		pinCtrl_nxt = pinCtrl_r;
		rdData_nxt = rdData_r;
		statusPulse_nxt = 1'b0;
		if (regWrEn)
		begin
			case (regAddr)
				CTRL0_OFFSET:
					statEn_nxt = regWrData[CTRL0_STAT_EN_BIT];
				CTRL1_OFFSET:
					ctrl1_nxt = regWrData;
				AUX_CTRL_OFFSET:
					auxCtrl_nxt = regWrData;
				PIN_CTRL_OFFSET:
					pinCtrl_nxt = {6'h00, regWrData[1:0]};
				default:
					statEn_nxt = statEn_r;
			endcase
		end
		if (regRdEn)
		begin
			case (regAddr)
				CTRL0_OFFSET:
				begin
					rdData_nxt = {pinLevel, statEn_r, 2'b00, running, faultCode_r};
					faultCode_nxt = FAULT_NONE;
				end
				CTRL1_OFFSET:
					rdData_nxt = ctrl1_r;
				AUX_CTRL_OFFSET:
					rdData_nxt = auxCtrl_r;
				PIN_CTRL_OFFSET:
					rdData_nxt = pinCtrl_r;
				MONITOR_OFFSET:
					rdData_nxt = monitorLive;
				default:
					rdData_nxt = 8'h00;
			endcase
		end
		if (busPor)
			faultCode_nxt = FAULT_NONE;
		// hi-z drops the request, stopping register-started boost; pin-started boost keeps running
		if (ctrl1_nxt[CTRL1_HIZ_BIT])
			ctrl1_nxt[CTRL1_REQ_BIT] = 1'b0;
		if (faultNow)
		begin
			if (faultCode == FAULT_TIMER)
			begin
				statEn_nxt = CTRL0_STAT_EN_RESET;
				ctrl1_nxt = CTRL1_RESET;
				auxCtrl_nxt = AUX_CTRL_RESET;
				pinCtrl_nxt = PIN_CTRL_RESET;
			end
			ctrl1_nxt[CTRL1_REQ_BIT] = 1'b0;
			faultCode_nxt = faultCode;
			statusPulse_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			statEn_r <= CTRL0_STAT_EN_RESET;
			faultCode_r <= FAULT_NONE;
			ctrl1_r <= CTRL1_RESET;
			auxCtrl_r <= AUX_CTRL_RESET;
			pinCtrl_r <= PIN_CTRL_RESET;
			rdData_r <= 8'h00;
			statusPulse_r <= 1'b0;
		end
		else
		begin
			statEn_r <= statEn_nxt;
			faultCode_r <= faultCode_nxt;
			ctrl1_r <= ctrl1_nxt;
			auxCtrl_r <= auxCtrl_nxt;
			pinCtrl_r <= pinCtrl_nxt;
			rdData_r <= rdData_nxt;
			statusPulse_r <= statusPulse_nxt;
		end
	end

	// power stage decode
	assign regRdData = rdData_r;
	assign statusPinPulse = statusPulse_r;
	assign boostActive = running;
	assign powerStageHiZ = !running;
	assign prechargeSourceOn = state_r == ST_PRECHARGE;
	assign halfCurrentLimit = state_r == ST_SOFT_LOW;
	assign loopClosed = state_r == ST_RUN;
	assign boostSwitchOn = (state_r == ST_SOFT_LOW) || (state_r == ST_SOFT_FULL)
		|| ((state_r == ST_RUN) && !fbAbove);
	assign auxOutputOn = midAbove && !auxCtrl_r[AUX_DISABLE_BIT]
		&& !running && !hiZReq;
endmodule : boost_startup_fault_sequencer

// File: rtl/interval_if.sv
`timescale 1ns/1ps
interface interval_if;
	logic restart;
	logic [boost_seq_pkg::TIMER_W-1:0] limit;
	logic tick;
	logic expired;
	modport owner (output restart, output limit, input tick, input expired);
	modport counter (input restart, input limit, output tick, output expired);
endinterface : interval_if

// File: rtl/interval_timer.sv
`timescale 1ns/1ps
module interval_timer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// owner side
	interval_if.counter tmr
);
	import boost_seq_pkg::*;

	logic [7:0] div_r;
	logic [7:0] div_nxt;
	logic [TIMER_W-1:0] count_r;
	logic [TIMER_W-1:0] count_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb
	begin
		div_nxt = div_r + 8'h01;
		tick_nxt = 1'b0;
		count_nxt = count_r;
		if (div_r == 8'(TICK_CYCLES - 1))
		begin
			div_nxt = 8'h00;
			tick_nxt = 1'b1;
		end
		if (tick_r && (count_r != {TIMER_W{1'b1}}))
			count_nxt = count_r + 1'b1;
		// count restarts on every state entry
		if (tmr.restart)
		begin
			div_nxt = 8'h00;
			tick_nxt = 1'b0;
			count_nxt = '0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			div_r <= 8'h00;
			tick_r <= 1'b0;
			count_r <= '0;
		end
		else
		begin
			div_r <= div_nxt;
			tick_r <= tick_nxt;
			count_r <= count_nxt;
		end
	end

	assign tmr.tick = tick_r;
	assign tmr.expired = (count_r >= tmr.limit);
endmodule : interval_timer
